// ### bench/cbtm_ctrl_model.sv
// controller-side model driving clock enable, command bus and strobe lane
`timescale 1ns/10ps
module cbtm_ctrl_model (
    // clock
    input wire logic clk_i,
    // command bus, strobe lane zero and data lanes
    output logic cke_o,
    output logic cs_o,
    output logic [5:0] ca_o,
    output logic strobe_o,
    output logic [6:0] dq_o
);
    // idle levels: clock enable high, select low, strobe low
    initial
    begin
        cke_o = 1'b1;
        cs_o = 1'b0;
        ca_o = 6'h15;
        strobe_o = 1'b0;
        dq_o = 7'h2a;
    end
    // unsampled lines wander so stale values never pass for valid ones
    task automatic idle(input int n);
        repeat (n)
        begin
            @(negedge clk_i);
            ca_o <= ~ca_o;
            dq_o <= ~dq_o;
        end
    endtask
    // entry: strobe idle, then enable low with clock kept running
    task automatic enter();
        @(negedge clk_i);
        strobe_o <= 1'b0;
        idle(1);
        cke_o <= 1'b0;
        idle(10);
    endtask
    // one select pulse, or two back to back when too_close is set
    task automatic sample(input logic [5:0] a, input logic [5:0] b, input logic too_close);
        @(negedge clk_i);
        cs_o <= 1'b1;
        ca_o <= a;
        if (too_close)
        begin
            @(negedge clk_i);
            ca_o <= b;
        end
        @(negedge clk_i);
        cs_o <= 1'b0;
        ca_o <= ~ca_o;
        idle(1);
    endtask
    // reference capture: value held static across every strobe edge
    task automatic vref(input logic [6:0] v, input int pulses);
        @(negedge clk_i);
        dq_o <= v;
        repeat (pulses * 2)
        begin
            @(negedge clk_i);
            strobe_o <= ~strobe_o;
        end
        @(negedge clk_i);
        dq_o <= ~v;
    endtask
    // exit: select low and clock valid before enable rises, strobe kept driven
    task automatic leave();
        idle(3);
        cke_o <= 1'b1;
        idle(10);
    endtask
endmodule

// ### bench/command_bus_training_mode_bench.sv
// self-checking bench for the command-bus training block
`timescale 1ns/10ps
module command_bus_training_mode_bench;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic mrw_pair_i = 1'b0;
    logic mrw_train_en_i = 1'b0;
    logic operating_setpoint_select_i = 1'b0;
    logic [6:0] ca_reference_register_i = 7'h20;
    logic [1:0] command_bus_termination_i = 2'h0;
    logic term_pad_strapped_off_i = 1'b0;
    logic cke_i, cs_i, strobe_t_i, dq_echo_oe_o, active_setpoint_o;
    logic term_enable_o, decode_enable_o, training_o, ref_settled_o;
    logic [5:0] ca_i, dq_echo_o, m_ca;
    logic [6:0] dq_i, command_bus_reference_level_o, v;
    logic [6:0] m_ref = cbtm_pkg::REF_RESET;
    int fail_count = 0;
    int num_checks = 0;
    int m_tr = 0;
    int i;

    // 40 MHz clock
    always #12.5 clk_i = ~clk_i;

    cbtm_core cbtm_core_inst (.clk_i, .reset_n_i, .mrw_pair_i, .mrw_train_en_i, .operating_setpoint_select_i,
        .ca_reference_register_i, .command_bus_termination_i, .term_pad_strapped_off_i, .cke_i, .cs_i, .ca_i,
        .strobe_t_i, .dq_i, .dq_echo_o, .dq_echo_oe_o, .active_setpoint_o, .term_enable_o, .decode_enable_o,
        .training_o, .command_bus_reference_level_o, .ref_settled_o);
    cbtm_ctrl_model cbtm_ctrl_model_inst (.clk_i(clk_i), .cke_o(cke_i), .cs_o(cs_i), .ca_o(ca_i),
        .strobe_o(strobe_t_i), .dq_o(dq_i));

    task automatic report(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // mode outputs against the model; training swaps to the other set-point
    task automatic check_mode();
        logic op;
        op = operating_setpoint_select_i ^ (m_tr != 0);
        report({4'h0, training_o, decode_enable_o, active_setpoint_o, term_enable_o},
            {4'h0, m_tr[0], ~m_tr[0], op, command_bus_termination_i[op] & ~term_pad_strapped_off_i});
    endtask
    task automatic check_ref(input logic s);
        report({ref_settled_o, command_bus_reference_level_o}, {s, m_ref});
    endtask
    // echo data only meaningful while driven
    task automatic check_echo(input logic oe);
        report({1'b0, dq_echo_oe_o, dq_echo_o & {6{oe}}}, {1'b0, oe, m_ca & {6{oe}}});
    endtask
    task automatic arm(input logic en);
        @(negedge clk_i);
        mrw_pair_i <= 1'b1;
        mrw_train_en_i <= en;
        @(negedge clk_i);
        mrw_pair_i <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // watchdog well beyond the roughly 310 cycles the tests need
    initial
    begin
        repeat (4000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end

    initial
    begin
        void'($urandom(19156));
        m_ca = 6'h00;
        repeat (10) @(negedge clk_i);
        check_mode();
        check_ref(1'b1);
        check_echo(1'b0);
        repeat (10) @(negedge clk_i);
        reset_n_i <= 1'b1;
        repeat (5) @(negedge clk_i);
        $display("test reset done");
        // strobes and selects outside training are ignored
        m_ref = ca_reference_register_i;
        cbtm_ctrl_model_inst.vref(7'($urandom), 2);
        cbtm_ctrl_model_inst.sample(6'($urandom), 6'h00, 1'b0);
        cbtm_ctrl_model_inst.idle(10);
        check_ref(1'b1);
        check_echo(1'b0);
        $display("test idle refusal done");
        // a disarmed block ignores clock enable falling
        arm(1'b1);
        arm(1'b0);
        cbtm_ctrl_model_inst.enter();
        check_mode();
        cbtm_ctrl_model_inst.leave();
        $display("test disarm done");
        // every set-point and strap combination, alternate set-point preloaded first
        for (i = 0; i < 4; i++)
        begin
            operating_setpoint_select_i <= i[0];
            term_pad_strapped_off_i <= i[1];
            command_bus_termination_i <= 2'($urandom);
            ca_reference_register_i <= {i[1], 6'($urandom_range(40, 0))};
            arm(1'b1);
            m_ref = ca_reference_register_i;
            cbtm_ctrl_model_inst.enter();
            m_tr = 1;
            check_mode();
            m_ca = 6'($urandom);
            cbtm_ctrl_model_inst.sample(m_ca, m_ca, 1'b0);
            check_echo(1'b1);
            m_ca = 6'($urandom);
            cbtm_ctrl_model_inst.sample(~m_ca, m_ca, 1'b1);
            check_echo(1'b1);
            // multi-step update, long settling
            v = {m_ref[6], m_ref[5:0] + 6'h05};
            cbtm_ctrl_model_inst.vref(v, 2);
            check_ref(1'b0);
            // a static multi-step value must not take the short wait
            cbtm_ctrl_model_inst.idle(8);
            check_ref(1'b0);
            m_ref = v;
            cbtm_ctrl_model_inst.idle(2);
            check_ref(1'b1);
            // single step with a single pulse, short settling
            v = {m_ref[6], m_ref[5:0] + 6'h01};
            cbtm_ctrl_model_inst.vref(v, 1);
            check_ref(1'b0);
            m_ref = v;
            cbtm_ctrl_model_inst.idle(3);
            check_ref(1'b1);
            cbtm_ctrl_model_inst.leave();
            m_tr = 0;
            m_ref = ca_reference_register_i;
            check_mode();
            check_ref(1'b1);
            check_echo(1'b0);
            arm(1'b0);
            $display("test training pass %0d done", i);
        end
        finish_test();
    end
endmodule

// ### verilog/cbtm_core.sv
// command-bus training mode logic of the memory device
`timescale 1ns/10ps
// Overview of operation
// (R1) training armed/disarmed by the two-part write setting or clearing the enable bit
// (R2) in training dq[5:0] is the reference value, dq[6] its range
// (R3) ca[5:0] sampled on chip select are echoed on dq[13:8]
// (R4) clock enable falling while armed switches to the inverse set-point
// (R5) clock enable low in training stops command decoding
// (R6) controller keeps clock running, select low, max(5ns,5 clocks) after enable low
// (R7) after that interval controller may stop or change the clock
// (R8) controller holds strobe idle 10 ns before enable falls
// (R9) controller waits 250 ns after enable falls before first sample
// (R10) controller gives at least two strobe pulses per capture; the bench's single-step test gives one
// (R11) each strobe edge overwrites the value, applied within 250 ns
// (R12) one-step or static update applies within 80 ns; a static multi-step update here takes the 250 ns wait
// (R13) controller gives valid clock around chip select high
// (R14) echoed data valid within 20 ns of the sample
// (R15) samples spaced by echo delay; otherwise only the last echo is kept
// (R16) controller restores frequency and clock before raising enable
// (R17) select low for the valid-clock interval before enable rises
// (R18) enable rising reverts to the set-point and termination used at entry
// (R19) trained values discarded on exit, original reference restored
// (R20) no termination if alternate set-point disables it or pad strapped off
// (R21) controller should preload the alternate set-point before training
// (R22) controller drives strobes 10 ns after enable rises
// (R23) controller allows 20 ns after enable edge for termination change
// (R24) next command waits max(5 clocks,200 ns), or 250 ns on range change
module cbtm_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // mode-register side
    input wire logic mrw_pair_i,
    input wire logic mrw_train_en_i,
    input wire logic operating_setpoint_select_i,
    input wire logic [6:0] ca_reference_register_i,
    input wire logic [1:0] command_bus_termination_i,
    input wire logic term_pad_strapped_off_i,
    // command bus
    input wire logic cke_i,
    input wire logic cs_i,
    input wire logic [5:0] ca_i,
    // strobe lane zero and data lanes
    input wire logic strobe_t_i,
    input wire logic [6:0] dq_i,
    // outputs
    output logic [5:0] dq_echo_o,
    output logic dq_echo_oe_o,
    output logic active_setpoint_o,
    output logic term_enable_o,
    output logic decode_enable_o,
    output logic training_o,
    output logic [6:0] command_bus_reference_level_o,
    output logic ref_settled_o
);
    logic rst_s1_q;
    logic rst_n_q;
    cbtm_pkg::cbtm_state_t state_q;
    logic cke_q;
    logic strobe_q;
    logic entry_sp_q;
    logic [6:0] cap_q;
    logic cap_pending_q;
    logic settle_done;
    logic strobe_edge;
    logic one_step;
    logic [5:0] ca_hold_q;

    // reset release through two flops
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // edge history of enable and strobe
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            cke_q <= 1'b1;
            strobe_q <= 1'b0;
        end
        else
        begin
            cke_q <= cke_i;
            strobe_q <= strobe_t_i;
        end
    end

    // any strobe edge in training captures, the first one included; the host should still pulse twice
    assign strobe_edge = (strobe_t_i != strobe_q); // see (R10)

    // mode sequencing
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            state_q <= cbtm_pkg::CBTM_IDLE;
        else
        begin
            case (state_q)
                cbtm_pkg::CBTM_IDLE:
                    if (mrw_pair_i && mrw_train_en_i)
                        state_q <= cbtm_pkg::CBTM_ARMED; // see (R1)
                cbtm_pkg::CBTM_ARMED:
                    if (mrw_pair_i && !mrw_train_en_i)
                        state_q <= cbtm_pkg::CBTM_IDLE; // see (R1)
                    else if (cke_q && !cke_i)
                        state_q <= cbtm_pkg::CBTM_TRAIN; // see (R4)
                cbtm_pkg::CBTM_TRAIN:
                    if (!cke_q && cke_i)
                        state_q <= cbtm_pkg::CBTM_ARMED; // see (R18)
                default:
                    state_q <= cbtm_pkg::CBTM_IDLE;
            endcase
        end
    end

    // set-point in use: inverse at entry, original restored on exit
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            entry_sp_q <= 1'b0;
            active_setpoint_o <= 1'b0;
        end
        else if (state_q == cbtm_pkg::CBTM_ARMED && cke_q && !cke_i)
        begin
            entry_sp_q <= operating_setpoint_select_i;
            active_setpoint_o <= !operating_setpoint_select_i; // see (R4)
        end
        else if (state_q == cbtm_pkg::CBTM_TRAIN)
            active_setpoint_o <= (!cke_q && cke_i) ? entry_sp_q : active_setpoint_o; // see (R18)
        else
            active_setpoint_o <= operating_setpoint_select_i;
    end

    // termination follows the active set-point, never with pad strapped off
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            term_enable_o <= 1'b0;
        else
            term_enable_o <= !term_pad_strapped_off_i
                && command_bus_termination_i[active_setpoint_o]; // see (R20) (R18)
    end

    // decoding off while training with enable low
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            decode_enable_o <= 1'b1;
            training_o <= 1'b0;
        end
        else
        begin
            decode_enable_o <= !(state_q == cbtm_pkg::CBTM_TRAIN || (state_q == cbtm_pkg::CBTM_ARMED
                && cke_q && !cke_i)); // see (R5)
            training_o <= (state_q == cbtm_pkg::CBTM_TRAIN);
        end
    end

    // capture dq[6:0] on each strobe edge, later edges overwrite
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            cap_q <= cbtm_pkg::REF_RESET;
            cap_pending_q <= 1'b0;
        end
        else if (state_q == cbtm_pkg::CBTM_TRAIN && strobe_edge)
        begin
            cap_q <= {dq_i[cbtm_pkg::REF_RANGE_BIT], dq_i[cbtm_pkg::REF_VALUE_W-1:0]}; // see (R2) (R11)
            cap_pending_q <= 1'b1;
        end
        else if (settle_done || state_q != cbtm_pkg::CBTM_TRAIN)
            cap_pending_q <= 1'b0;
    end

    // short settling needs a single step in the same range, and a lone pulse or a static value
    assign one_step = (dq_i[6] == command_bus_reference_level_o[6])
        && ((dq_i[5:0] == command_bus_reference_level_o[5:0] + 6'h01)
        || (dq_i[5:0] + 6'h01 == command_bus_reference_level_o[5:0]))
        && (!cap_pending_q || dq_i[6:0] == cap_q); // see (R12)

    cbtm_settle u_settle (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .start_i(state_q == cbtm_pkg::CBTM_TRAIN && strobe_edge),
        .short_i(one_step),
        .done_o(settle_done)
    );

    // temporary reference in training; original restored otherwise
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            command_bus_reference_level_o <= cbtm_pkg::REF_RESET;
            ref_settled_o <= 1'b1;
        end
        else if (state_q != cbtm_pkg::CBTM_TRAIN)
        begin
            command_bus_reference_level_o <= ca_reference_register_i; // see (R19)
            ref_settled_o <= 1'b1;
        end
        else if (settle_done && cap_pending_q)
        begin
            command_bus_reference_level_o <= cap_q; // see (R11)
            ref_settled_o <= 1'b1;
        end
        else if (strobe_edge)
            ref_settled_o <= 1'b0;
    end

    // ca sampled on select; newer sample overwrites an older pending one
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
            ca_hold_q <= cbtm_pkg::ECHO_RESET;
        else if (state_q == cbtm_pkg::CBTM_TRAIN && cs_i)
            ca_hold_q <= ca_i; // see (R3) (R15)
    end

    // echo lands on the same edge as the sample, well inside the read bound
    always_ff @(posedge clk_i or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            dq_echo_o <= cbtm_pkg::ECHO_RESET;
            dq_echo_oe_o <= 1'b0;
        end
        else
        begin
            dq_echo_o <= (state_q == cbtm_pkg::CBTM_TRAIN && cs_i) ? ca_i : ca_hold_q; // see (R14)
            dq_echo_oe_o <= (state_q == cbtm_pkg::CBTM_TRAIN) && !(!cke_q && cke_i);
        end
    end

    property p_echo_follows;
        @(posedge clk_i) disable iff (!rst_n_q)
        (state_q == cbtm_pkg::CBTM_TRAIN && cs_i) |=> (dq_echo_o == $past(ca_i));
    endproperty
    a_echo_follows: assert property (p_echo_follows) else $error("echo mismatch"); // see (R14)
    property p_inverse_sp;
        @(posedge clk_i) disable iff (!rst_n_q)
        (state_q == cbtm_pkg::CBTM_ARMED && cke_q && !cke_i)
        |=> (active_setpoint_o == !$past(operating_setpoint_select_i));
    endproperty
    a_inverse_sp: assert property (p_inverse_sp) else $error("set-point not inverted"); // see (R4)
    property p_revert_sp;
        @(posedge clk_i) disable iff (!rst_n_q)
        (state_q == cbtm_pkg::CBTM_TRAIN && !cke_q && cke_i) |=> (active_setpoint_o == $past(entry_sp_q));
    endproperty
    a_revert_sp: assert property (p_revert_sp) else $error("set-point not restored"); // see (R18)
    property p_no_decode;
        @(posedge clk_i) disable iff (!rst_n_q)
        (state_q == cbtm_pkg::CBTM_TRAIN) |=> !decode_enable_o;
    endproperty
    a_no_decode: assert property (p_no_decode) else $error("decoding in training"); // see (R5)
    property p_strap_off;
        @(posedge clk_i) disable iff (!rst_n_q)
        term_pad_strapped_off_i |=> !term_enable_o;
    endproperty
    a_strap_off: assert property (p_strap_off) else $error("termination on with strap"); // see (R20)
    sequence s_capture;
        state_q == cbtm_pkg::CBTM_TRAIN && strobe_edge && !one_step;
    endsequence
    property p_settle_long;
        @(posedge clk_i) disable iff (!rst_n_q)
        s_capture ##1 (state_q == cbtm_pkg::CBTM_TRAIN && !strobe_edge)[*8] |-> ##[0:3] ref_settled_o;
    endproperty
    a_settle_long: assert property (p_settle_long) else $error("reference slow to settle"); // see (R11)
    property p_discard;
        @(posedge clk_i) disable iff (!rst_n_q)
        (state_q == cbtm_pkg::CBTM_IDLE) ##1 (state_q == cbtm_pkg::CBTM_IDLE)
        |-> (command_bus_reference_level_o == $past(ca_reference_register_i));
    endproperty
    a_discard: assert property (p_discard) else $error("trained value kept"); // see (R19)
    property p_arm;
        @(posedge clk_i) disable iff (!rst_n_q)
        (state_q == cbtm_pkg::CBTM_IDLE && mrw_pair_i && mrw_train_en_i) |=> (state_q == cbtm_pkg::CBTM_ARMED);
    endproperty
    a_arm: assert property (p_arm) else $error("arm write ignored"); // see (R1)
    property p_capture;
        @(posedge clk_i) disable iff (!rst_n_q)
        (state_q == cbtm_pkg::CBTM_TRAIN && strobe_edge) |=> (cap_q == $past(dq_i));
    endproperty
    a_capture: assert property (p_capture) else $error("capture mismatch"); // see (R2)
endmodule

// ### verilog/cbtm_pkg.sv
// constants for the command-bus training block
package cbtm_pkg;
    // clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS = 25000;
    // settling and echo bounds, nanoseconds as printed
    localparam int unsigned VREF_LONG_NS = 250;
    localparam int unsigned VREF_SHORT_NS = 80;
    localparam int unsigned ECHO_READ_DELAY_NS = 20;
    // longest times round down, never below one cycle
    localparam int unsigned VREF_LONG_CYC_RAW = (VREF_LONG_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned VREF_SHORT_CYC_RAW = (VREF_SHORT_NS * 1000) / CLK_PERIOD_PS;
    localparam int unsigned ECHO_CYC_RAW = (ECHO_READ_DELAY_NS * 1000) / CLK_PERIOD_PS;
    localparam logic [3:0] VREF_LONG_CYC = 4'(VREF_LONG_CYC_RAW < 1 ? 1 : VREF_LONG_CYC_RAW);
    localparam logic [3:0] VREF_SHORT_CYC = 4'(VREF_SHORT_CYC_RAW < 1 ? 1 : VREF_SHORT_CYC_RAW);
    localparam logic [3:0] ECHO_CYC = 4'(ECHO_CYC_RAW < 1 ? 1 : ECHO_CYC_RAW);
    // field layout of the dq capture byte
    localparam int unsigned REF_VALUE_W = 6;
    localparam int unsigned REF_RANGE_BIT = 6;
    localparam int unsigned CA_W = 6;
    // reset values
    localparam logic [6:0] REF_RESET = 7'h00;
    localparam logic [5:0] ECHO_RESET = 6'h00;
    // mode-state encoding
    typedef enum logic [1:0] {
        CBTM_IDLE = 2'b00,
        CBTM_ARMED = 2'b01,
        CBTM_TRAIN = 2'b10
    } cbtm_state_t;
endpackage

// ### verilog/cbtm_settle.sv
// settling timer for a temporary reference update
`timescale 1ns/10ps
module cbtm_settle (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // control
    input wire logic start_i,
    input wire logic short_i,
    // status
    output logic done_o
);
    logic [3:0] cnt_q;

    // reload on every capture; a new strobe restarts the wait
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cnt_q <= 4'h0;
        else if (start_i)
            cnt_q <= short_i ? cbtm_pkg::VREF_SHORT_CYC : cbtm_pkg::VREF_LONG_CYC;
        else if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
    end

    // done is high for the one cycle in which the count stands at one;
    // left unregistered so the update lands on the settling bound, not a clock past it
    always_comb
    begin
        done_o = !start_i && (cnt_q == 4'h1);
    end
endmodule
